/* pkg/fpmc_pkg.sv */
/*
 * constants, field layout and carrier types of the package-writing control block.
 * assumes one clock domain and a register access port fed by the serial interface decoder.
 */
// Notes on behaviour
// (R1) protection off: packages go to the fifo with no free-space check.
// (R2) protection on: store only if whole package fits, else drop it whole.
// (R3) marking on: first word lsb forced to one, later words lsb forced zero.
// (R4) auto-switch in near mode: second near-on event moves to sample mode after storing.
// (R5) auto-switch off: mode only ever changes by software write.
// (R6) sample mode gating on: only samples between gesture start and end are stored.
// (R7) near decimation codes 0..5 give 1,2,4,8,16,32; other codes give 32.
// (R8) mode codes: 0 standby, 1 near mode, 3 sample mode.
// (R9) near package: one word intensity or three words x,y,intensity; other formats none.
// (R10) after auto-switch the mode field reads back the sample code.
`default_nettype none
package fpmc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  FPMC_OPCTL_ADDR  = 8'h45;
    localparam logic [7:0]  FPMC_NDEC_ADDR   = 8'h46;
    localparam logic [15:0] FPMC_OPCTL_RST   = 16'h0000;
    localparam logic [15:0] FPMC_NDEC_RST    = 16'h0000;
    localparam logic [15:0] FPMC_OPCTL_MASK  = 16'h37ff;
    localparam logic [15:0] FPMC_NDEC_MASK   = 16'h0007;

    localparam int FPMC_MODE_LSB    = 0;
    localparam int FPMC_FMT_LSB     = 4;
    localparam int FPMC_PROTECT_BIT = 8;
    localparam int FPMC_MARK_BIT    = 9;
    localparam int FPMC_AUTO_BIT    = 10;
    localparam int FPMC_GATE_BIT    = 12;
    localparam int FPMC_NDEC_LSB    = 0;

    // ****************************************
    // codes and counts
    // ****************************************
    localparam logic [3:0] FPMC_MODE_STANDBY = 4'h0;
    localparam logic [3:0] FPMC_MODE_NEAR    = 4'h1;
    localparam logic [3:0] FPMC_MODE_SAMPLE  = 4'h3;
    localparam logic [3:0] FPMC_FMT_I        = 4'h1;
    localparam logic [3:0] FPMC_FMT_XYI      = 4'h3;
    localparam logic [1:0] FPMC_LEN_I        = 2'h1;
    localparam logic [1:0] FPMC_LEN_XYI      = 2'h3;
    localparam logic [1:0] FPMC_LEN_SAMPLE   = 2'h2;
    localparam int         FPMC_FIFO_DEPTH   = 16;
    localparam int         FPMC_WORD_W       = 16;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        is_sample;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] i;
    } fpmc_meas_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fpmc_reg_req_t;

    typedef enum logic {FPMC_IDLE, FPMC_WRITE} fpmc_state_t;

endpackage
`default_nettype wire

/* rtl/fpmc_core.sv */
/*
 * package-writing control: mode and format registers, near decimation, sample gating,
 * overrun protection, start marking and near-to-sample auto-switch, feeding the output fifo.
 * assumes register requests come decoded from the serial interface, one per cycle,
 * and that measurement and event inputs are synchronous to clk_in.
 */
`default_nettype none
module fpmc_core
    import fpmc_pkg::*;
#(
    parameter int FIFO_DEPTH = FPMC_FIFO_DEPTH
) (
    input  wire logic                            clk_in,
    input  wire logic                            rst_in,
    input  wire fpmc_reg_req_t                   reg_req_in,
    output logic [15:0]                          reg_rdata_out,
    input  wire fpmc_meas_t                      meas_in,
    input  wire logic                            meas_valid_in,
    output logic                                 meas_ready_out,
    input  wire logic                            near_on2_in,
    input  wire logic                            gesture_start_in,
    input  wire logic                            gesture_end_in,
    output logic [FPMC_WORD_W-1:0]               fifo_data_out,
    output logic                                 fifo_valid_out,
    input  wire logic                            fifo_ready_in,
    output logic [$clog2(FIFO_DEPTH+1)-1:0]      fifo_level_out,
    output logic [3:0]                           operating_mode_select_out,
    output logic                                 drop_out
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    // ****************************************
    // registers
    // ****************************************
    logic [15:0]       opctl_reg;
    logic [15:0]       ndec_reg;
    fpmc_state_t       state_reg;
    logic [2:0][15:0]  words_reg;
    logic [1:0]        len_reg;
    logic [1:0]        idx_reg;
    logic [4:0]        dec_cnt_reg;
    logic              window_reg;
    logic              pend_reg;

    logic [3:0]        operating_mode_select;
    logic [3:0]        out_fmt;
    logic              protect_en;
    logic              package_mark_enable;
    logic              near_to_sample_autoswitch;
    logic              sample_output_gating;
    logic [2:0]        near_decimation_rate;
    logic              op_wr;
    logic              accept;
    logic              near_seen;
    logic [1:0]        pkg_len;
    logic [CW-1:0]     space;
    logic              room;
    logic              take;
    logic              drop;
    logic              switch_now;
    logic [4:0]        rate_m1;
    logic [15:0]       push_data;
    logic              push_ready;
    logic              push_fire;
    logic [CW-1:0]     lvl;

    assign operating_mode_select                   = opctl_reg[FPMC_MODE_LSB +: 4];
    assign out_fmt                   = opctl_reg[FPMC_FMT_LSB +: 4];
    assign protect_en                = opctl_reg[FPMC_PROTECT_BIT];
    assign package_mark_enable       = opctl_reg[FPMC_MARK_BIT];
    assign near_to_sample_autoswitch = opctl_reg[FPMC_AUTO_BIT];
    assign sample_output_gating      = opctl_reg[FPMC_GATE_BIT];
    assign near_decimation_rate      = ndec_reg[FPMC_NDEC_LSB +: 3];
    assign op_wr                     = reg_req_in.wr && (reg_req_in.addr == FPMC_OPCTL_ADDR);
    assign operating_mode_select_out               = operating_mode_select;
    assign fifo_level_out            = lvl;

    // ****************************************
    // decimation and package selection
    // ****************************************
    always_comb begin
        case (near_decimation_rate) // R7
            3'h0:    rate_m1 = 5'h00;
            3'h1:    rate_m1 = 5'h01;
            3'h2:    rate_m1 = 5'h03;
            3'h3:    rate_m1 = 5'h07;
            3'h4:    rate_m1 = 5'h0f;
            default: rate_m1 = 5'h1f;
        endcase
    end

    assign accept    = meas_valid_in && meas_ready_out;
    assign near_seen = accept && (operating_mode_select == FPMC_MODE_NEAR) && !meas_in.is_sample;

    always_comb begin
        pkg_len = 2'h0;
        if (near_seen && dec_cnt_reg == 5'h00) begin
            if (out_fmt == FPMC_FMT_I) begin // R9
                pkg_len = FPMC_LEN_I;
            end else if (out_fmt == FPMC_FMT_XYI) begin // R9
                pkg_len = FPMC_LEN_XYI;
            end
        end else if (accept && operating_mode_select == FPMC_MODE_SAMPLE && meas_in.is_sample &&
                     (!sample_output_gating || window_reg)) begin // R6
            pkg_len = FPMC_LEN_SAMPLE;
        end
    end

    assign space = CW'(FIFO_DEPTH) - lvl;
    assign room  = (space >= CW'(pkg_len));
    assign take  = (pkg_len != 2'h0) && (!protect_en || room); // R1 R2
    assign drop  = (pkg_len != 2'h0) && protect_en && !room; // R2

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dec_cnt_reg <= 5'h00;
        end else if (near_seen) begin
            dec_cnt_reg <= (dec_cnt_reg >= rate_m1) ? 5'h00 : 5'(dec_cnt_reg + 5'h01); // R7
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            window_reg <= 1'b0;
        end else if (gesture_start_in) begin
            window_reg <= 1'b1; // R6
        end else if (gesture_end_in) begin
            window_reg <= 1'b0;
        end
    end

    // ****************************************
    // package writer
    // ****************************************
    always_comb begin
        push_data = words_reg[idx_reg];
        if (package_mark_enable) begin
            push_data[0] = (idx_reg == 2'h0); // R3
        end
    end

    assign push_fire = (state_reg == FPMC_WRITE) && push_ready;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg      <= FPMC_IDLE;
            meas_ready_out <= 1'b1;
            len_reg        <= 2'h0;
            idx_reg        <= 2'h0;
            words_reg      <= '0;
        end else begin
            case (state_reg)
                FPMC_IDLE: begin
                    if (take) begin
                        state_reg      <= FPMC_WRITE;
                        meas_ready_out <= 1'b0;
                        len_reg        <= pkg_len;
                        idx_reg        <= 2'h0;
                        if (pkg_len == FPMC_LEN_I) begin
                            words_reg <= {16'h0000, 16'h0000, meas_in.i};
                        end else begin
                            words_reg <= {meas_in.i, meas_in.y, meas_in.x};
                        end
                    end
                end
                FPMC_WRITE: begin
                    if (push_fire) begin
                        idx_reg <= 2'(idx_reg + 2'h1);
                        if (2'(idx_reg + 2'h1) == len_reg) begin
                            state_reg      <= FPMC_IDLE;
                            meas_ready_out <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg      <= FPMC_IDLE;
                    meas_ready_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            drop_out <= 1'b0;
        end else begin
            drop_out <= drop;
        end
    end

    fpmc_fifo #(
        .WIDTH (FPMC_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_data_in    (push_data),
        .in_valid_in   (state_reg == FPMC_WRITE),
        .in_ready_out  (push_ready),
        .out_data_out  (fifo_data_out),
        .out_valid_out (fifo_valid_out),
        .out_ready_in  (fifo_ready_in),
        .level_out     (lvl)
    );

    // ****************************************
    // mode register and auto-switch
    // ****************************************
    // switch waits until the writer is idle so the event's package is fully stored
    assign switch_now = pend_reg && (state_reg == FPMC_IDLE) && !take; // R4

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_reg <= 1'b0;
        end else if (op_wr || !near_to_sample_autoswitch || operating_mode_select != FPMC_MODE_NEAR) begin
            pend_reg <= 1'b0; // R5
        end else if (near_on2_in) begin
            pend_reg <= 1'b1; // R4
        end else if (switch_now) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            opctl_reg <= FPMC_OPCTL_RST;
            ndec_reg  <= FPMC_NDEC_RST;
        end else begin
            if (op_wr) begin
                opctl_reg <= reg_req_in.wdata & FPMC_OPCTL_MASK; // R8
            end else if (switch_now) begin
                opctl_reg[FPMC_MODE_LSB +: 4] <= FPMC_MODE_SAMPLE; // R4 R10
            end
            if (reg_req_in.wr && reg_req_in.addr == FPMC_NDEC_ADDR) begin
                ndec_reg <= reg_req_in.wdata & FPMC_NDEC_MASK;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                FPMC_OPCTL_ADDR: reg_rdata_out <= opctl_reg; // R10
                FPMC_NDEC_ADDR:  reg_rdata_out <= ndec_reg;
                default:         reg_rdata_out <= 16'h0000;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_free_write_path: assert property ( // R1
        (state_reg == FPMC_IDLE && pkg_len != 2'h0 && !protect_en) |=>
            (state_reg == FPMC_WRITE && !meas_ready_out))
        else $error("package not written with protection off");

    a_whole_pkg_drop: assert property ( // R2
        drop |=> (drop_out && state_reg == FPMC_IDLE && meas_ready_out))
        else $error("refused package was partly stored");

    a_room_checked: assert property ( // R2
        (state_reg == FPMC_IDLE && take && protect_en) |=>
            ((CW+1)'(lvl) + (CW+1)'(len_reg) <= (CW+1)'(FIFO_DEPTH)))
        else $error("protected package accepted without room");

    a_mark_first_word: assert property ( // R3
        (push_fire && package_mark_enable) |->
            (push_data[0] == (idx_reg == 2'h0)))
        else $error("package start mark wrong");

    a_auto_switch_idle: assert property ( // R4
        (operating_mode_select == FPMC_MODE_NEAR && !op_wr ##1 operating_mode_select == FPMC_MODE_SAMPLE) |->
            $past(pend_reg && state_reg == FPMC_IDLE))
        else $error("auto-switch before package storing finished");

    a_no_auto_change: assert property ( // R5
        (!near_to_sample_autoswitch && !op_wr) |=> $stable(operating_mode_select))
        else $error("mode changed without software write");

    a_sample_gate: assert property ( // R6
        (take && operating_mode_select == FPMC_MODE_SAMPLE && sample_output_gating) |-> window_reg)
        else $error("sample stored outside gesture window");

    a_dec_wrap: assert property ( // R7
        (near_seen && dec_cnt_reg == rate_m1) |=> (dec_cnt_reg == 5'h00))
        else $error("near decimation count did not wrap");

    a_near_pkg_len: assert property ( // R9
        (take && operating_mode_select == FPMC_MODE_NEAR) |=>
            (len_reg == FPMC_LEN_I || len_reg == FPMC_LEN_XYI))
        else $error("near package length wrong");

    a_switch_readback: assert property ( // R10
        (switch_now && !op_wr) |=> (operating_mode_select_out == FPMC_MODE_SAMPLE) ##1
            ($past(op_wr) || operating_mode_select_out == FPMC_MODE_SAMPLE))
        else $error("mode field does not show sample after switch");

endmodule
`default_nettype wire

/* rtl/fpmc_fifo.sv */
/*
 * output fifo with a registered read stage; holds DEPTH words in memory.
 * assumes DEPTH is a power of two and a single clock.
 */
`default_nettype none
module fpmc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic [WIDTH-1:0]           in_data_in,
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    output logic [WIDTH-1:0]                out_data_out,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [$clog2(DEPTH+1)-1:0]      level_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    cnt_reg;
    logic             push;
    logic             load;

    assign in_ready_out = (cnt_reg < CW'(DEPTH));
    assign push         = in_valid_in && in_ready_out;
    assign load         = (cnt_reg != '0) && (!out_valid_out || out_ready_in);
    assign level_out    = cnt_reg;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            end
            if (load) begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            end
            cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(load));
        end
    end

    // read stage: memory data always leave through this register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else if (load) begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem_reg[rd_ptr_reg];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* sim/fpmc_host_model.sv */
/*
 * host model: register master and fifo reader facing the package-writing block.
 * assumes the bench calls its tasks from edge+2 and sets stall_all to hold the reader.
 */
`default_nettype none
module fpmc_host_model
    import fpmc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    output var fpmc_reg_req_t reg_req_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic [15:0] fifo_data_in,
    input  wire logic        fifo_valid_in,
    output logic             fifo_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] got[$];
    logic        stall_all = 1'b0;

    initial reg_req_out = '0;
    initial fifo_ready_out = 1'b0;

    // ****************************************
    // fifo reader, stalls at random
    // ****************************************
    always @(posedge clk_in) begin
        if (fifo_valid_in === 1'b1 && fifo_ready_out === 1'b1) begin
            got.push_back(fifo_data_in);
        end
        #2 fifo_ready_out = !rst_in && !stall_all && ($urandom_range(3) != 0);
    end

    // ****************************************
    // register accesses, one-cycle strobes
    // ****************************************
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #2 reg_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        #2 reg_req_out = '0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        #2 reg_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_in);
        #2 reg_req_out = '0;
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

/* sim/test_fifo_packaging_mode_control.sv */
/*
 * self-checking bench of the package-writing control block with a host model.
 * assumes the package constants and the design's documented port timing.
 */
`default_nettype none
module test_fifo_packaging_mode_control
    import fpmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk_in = 1'b0;
    logic          rst_in = 1'b1;
    fpmc_reg_req_t reg_req;
    fpmc_meas_t    meas = '0;
    logic [15:0]   rdata, fifo_data, rv, x, y, i;
    logic          meas_valid = 1'b0, meas_ready, on2 = 1'b0, g_start = 1'b0, g_end = 1'b0;
    logic          fifo_valid, fifo_ready, drop;
    logic [4:0]    level, max_level = 5'h0;
    logic [3:0]    operating_mode_select;
    logic [15:0]   sent[$];
    int            n_mismatch = 0, cmp_count = 0, n_drop = 0;

    always #12.5 clk_in = ~clk_in;

    fpmc_core #(.FIFO_DEPTH(16)) dut (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req),
        .reg_rdata_out(rdata), .meas_in(meas), .meas_valid_in(meas_valid),
        .meas_ready_out(meas_ready), .near_on2_in(on2), .gesture_start_in(g_start),
        .gesture_end_in(g_end), .fifo_data_out(fifo_data), .fifo_valid_out(fifo_valid),
        .fifo_ready_in(fifo_ready), .fifo_level_out(level), .operating_mode_select_out(operating_mode_select),
        .drop_out(drop));

    fpmc_host_model host (.clk_in(clk_in), .rst_in(rst_in), .reg_req_out(reg_req),
        .reg_rdata_in(rdata), .fifo_data_in(fifo_data), .fifo_valid_in(fifo_valid),
        .fifo_ready_out(fifo_ready));

    always @(posedge clk_in) begin
        if (drop === 1'b1) n_drop++;
        if (!rst_in && level > max_level) max_level <= level;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        n_mismatch++;
        $display("mismatch %s expected done seen timeout", what);
        give_verdict();
    endtask

    function automatic int dec_rate(input int code);
        return (code <= 5) ? (1 << code) : 32;
    endfunction

    // mode codes 0 standby, 1 near, 3 sample
    task automatic ctl(input logic [3:0] md, fmt, input logic prot, mark, auto, gate);
        host.write_reg(FPMC_OPCTL_ADDR, {3'h0, gate, 1'b0, auto, mark, prot, fmt, md});
        host.got.delete();
    endtask

    task automatic send(input logic s, input logic [15:0] a, b, c);
        int n;
        n = 0;
        @(posedge clk_in);
        #2 meas = '{is_sample: s, x: a, y: b, i: c};
        meas_valid = 1'b1;
        while (meas_ready !== 1'b1) begin
            @(posedge clk_in);
            #2;
            if (++n > 400) give_up("meas_ready");
        end
        @(posedge clk_in);
        #2 meas_valid = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk_in);
        #2 s = 1'b1;
        @(posedge clk_in);
        #2 s = 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        host.stall_all = 1'b0;
        repeat (4) @(posedge clk_in);
        while (fifo_valid !== 1'b0 || level !== 5'h0 || meas_ready !== 1'b1) begin
            @(posedge clk_in);
            if (++n > 600) give_up("drain");
        end
        repeat (3) @(posedge clk_in);
        #2;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(91));
        repeat (20) @(posedge clk_in);
        #2 rst_in = 1'b0;
        host.read_reg(FPMC_OPCTL_ADDR, rv);
        check("opctl reset", rv, FPMC_OPCTL_RST);
        host.read_reg(FPMC_NDEC_ADDR, rv);
        check("ndec reset", rv, FPMC_NDEC_RST);
        host.write_reg(FPMC_NDEC_ADDR, 16'hffff);
        host.read_reg(FPMC_NDEC_ADDR, rv);
        check("ndec field", rv, 16'h0007);
        host.write_reg(FPMC_OPCTL_ADDR, 16'hffff);
        host.read_reg(FPMC_OPCTL_ADDR, rv);
        check("opctl fields", rv, 16'h37ff);
        host.write_reg(8'h47, 16'hffff);
        host.read_reg(8'h47, rv);
        check("unmapped read", rv, 16'h0000);
        host.write_reg(FPMC_NDEC_ADDR, 16'h0000);
        // standby stores nothing
        ctl(FPMC_MODE_STANDBY, FPMC_FMT_I, 0, 0, 0, 0);
        check("standby mode", {12'h0, operating_mode_select}, 16'h0000);
        send(0, 16'h1234, 16'h5678, 16'h9abc);
        drain();
        check("standby words", 16'(host.got.size()), 16'h0000);
        // near formats, start marking on for formats 1 and 3, off for 0 and 2
        for (int f = 0; f < 4; f++) begin
            x = 16'($urandom());
            y = 16'($urandom());
            i = 16'($urandom());
            ctl(FPMC_MODE_NEAR, 4'(f), 0, f[0], 0, 0);
            check("near mode", {12'h0, operating_mode_select}, 16'h0001);
            send(0, x, y, i);
            drain();
            check("near words", 16'(host.got.size()), (f == 3) ? 16'h3 : 16'(f == 1));
            if (f == 3 && host.got.size() == 3) begin
                check("mark x", host.got[0], {x[15:1], 1'b1});
                check("mark y", host.got[1], {y[15:1], 1'b0});
                check("mark i", host.got[2], {i[15:1], 1'b0});
            end
            if (f == 1 && host.got.size() == 1) check("marked i", host.got[0], {i[15:1], 1'b1});
        end
        // decimation codes
        ctl(FPMC_MODE_NEAR, FPMC_FMT_I, 0, 0, 0, 0);
        for (int c = 0; c < 8; c++) begin
            host.write_reg(FPMC_NDEC_ADDR, 16'(c));
            host.got.delete();
            repeat (32) send(0, 16'h0, 16'h0, 16'($urandom()));
            drain();
            check("decimated words", 16'(host.got.size()), 16'(32 / dec_rate(c)));
        end
        host.write_reg(FPMC_NDEC_ADDR, 16'h0000);
        // no protection: fifo fills, writer waits, nothing lost
        ctl(FPMC_MODE_NEAR, FPMC_FMT_I, 0, 0, 0, 0);
        n_drop = 0;
        host.stall_all = 1'b1;
        fork
            begin
                repeat (200) @(posedge clk_in);
                host.stall_all = 1'b0;
            end
        join_none
        for (int k = 0; k < 24; k++) begin
            sent.push_back(16'($urandom()));
            send(0, 16'h0, 16'h0, sent[k]);
        end
        drain();
        check("full level", {11'h0, max_level}, 16'(FPMC_FIFO_DEPTH));
        check("unprotected drops", 16'(n_drop), 16'h0);
        check("unprotected words", 16'(host.got.size()), 16'd24);
        foreach (host.got[k]) check("unprotected data", host.got[k], sent[k]);
        // protection: whole packages dropped while the reader is held
        ctl(FPMC_MODE_NEAR, FPMC_FMT_XYI, 1, 1, 0, 0);
        n_drop = 0;
        host.stall_all = 1'b1;
        repeat (8) send(0, 16'($urandom()), 16'($urandom()), 16'($urandom()));
        drain();
        check("protected drops", 16'(n_drop), 16'h3);
        check("protected words", 16'(host.got.size()), 16'd15);
        foreach (host.got[k]) check("start bit", {15'h0, host.got[k][0]}, 16'(k % 3 == 0));
        // auto-switch waits for the package being stored
        ctl(FPMC_MODE_NEAR, FPMC_FMT_XYI, 0, 0, 1, 0);
        send(0, 16'h1111, 16'h2222, 16'h3333);
        pulse(on2);
        repeat (4) @(posedge clk_in);
        #2;
        check("auto mode", {12'h0, operating_mode_select}, 16'h0003);
        host.read_reg(FPMC_OPCTL_ADDR, rv);
        check("auto readback", {12'h0, rv[3:0]}, 16'h0003);
        drain();
        check("words before switch", 16'(host.got.size()), 16'h3);
        ctl(FPMC_MODE_NEAR, FPMC_FMT_I, 0, 0, 0, 0);
        pulse(on2);
        repeat (10) @(posedge clk_in);
        #2;
        check("no auto mode", {12'h0, operating_mode_select}, 16'h0001);
        // sample gating window
        ctl(FPMC_MODE_SAMPLE, 4'h0, 0, 0, 0, 1);
        send(1, 16'haaaa, 16'hbbbb, 16'h0);
        pulse(g_start);
        send(1, 16'h0c0c, 16'h0d0d, 16'h0);
        pulse(g_end);
        send(1, 16'heeee, 16'hffff, 16'h0);
        drain();
        check("gated words", 16'(host.got.size()), 16'h2);
        if (host.got.size() == 2) check("gated x", host.got[0], 16'h0c0c);
        ctl(FPMC_MODE_SAMPLE, 4'h0, 0, 0, 0, 0);
        send(1, 16'h0101, 16'h0202, 16'h0);
        drain();
        check("ungated words", 16'(host.got.size()), 16'h2);
        give_verdict();
    end
endmodule
`default_nettype wire
